// >>> design/rps_sequencer.sv
`timescale 1ns/100ps
module rps_sequencer #(
  parameter int WDOG_RC_EDGES = rps_pkg::WDOG_RC_EDGES
) (
  input wire logic sys_clk_in, // 250 MHz system clock
  input wire logic rstn_in, // sync reset, active low
  input wire logic ext_reset_n_in, // external reset pin, active low
  input wire logic pad_por_ok_in, // pad supply above release threshold
  input wire logic core_por_ok_in, // core supply above release threshold
  input wire logic core_dip_in, // core supply dip detected
  input wire logic rc_clk_in, // 10 kHz rc oscillator
  input wire logic xtal_clk_in, // 24 MHz crystal clock
  input wire logic wdog_kick_in, // firmware restarts watchdog, pulse
  input wire logic pc_rollover_in, // program counter rolled over, pulse
  input wire logic sw_reset_in, // software reset request, pulse
  input wire logic dbg_fip_unlock_in, // debug port enables page writes
  input wire logic dbg_fip_lock_in, // debug port disables page writes
  input wire logic fw_fip_write_in, // firmware page write request
  output logic pad_reset_n_out, // pad domain reset, active low
  output logic core_reset_n_out, // core domain reset, active low
  output logic [rps_pkg::CAUSE_W-1:0] reset_cause_out, // one-hot cause
  output logic fip_prog_en_out, // factory page programming enabled
  output logic fip_write_ok_out // firmware page write allowed
);
  logic ext_s_n;
  logic pad_por_s;
  logic core_por_s;
  logic dip_s;
  logic rc_s;
  logic xtal_s;
  logic [rps_pkg::EXT_FILT_W-1:0] filt_cnt;
  logic ext_rst_act;
  logic por_lvl;
  logic core_hold;
  logic any_cause;
  logic [rps_pkg::CAUSE_W-1:0] next_cause;

  rps_cnt_if pad_cnt ();
  rps_cnt_if xtal_cnt ();
  rps_cnt_if wdog_cnt ();

  // pin levels from other domains pass two flip-flops
  rps_sync #(
    .W(6)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .async_in({ext_reset_n_in, pad_por_ok_in, core_por_ok_in,
               core_dip_in, rc_clk_in, xtal_clk_in}),
    .sync_out({ext_s_n, pad_por_s, core_por_s, dip_s, rc_s, xtal_s})
  );

  // glitch filter: reset only after EXT_FILT_CYC low samples
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || ext_s_n) begin
      filt_cnt <= '0;
    end else if (!ext_rst_act) begin
      filt_cnt <= filt_cnt + rps_pkg::EXT_FILT_W'(1);
    end
  end

  assign ext_rst_act =
    (filt_cnt == rps_pkg::EXT_FILT_W'(rps_pkg::EXT_FILT_CYC));

  // pad domain release after three rc pulses with pad supply good
  assign pad_cnt.edge_lvl = rc_s;
  assign pad_cnt.clr = ~pad_por_s;

  rps_edge_cnt #(
    .W(rps_pkg::RC_CNT_W),
    .TARGET(rps_pkg::RC_PULSES)
  ) u_pad_cnt (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .cnt(pad_cnt)
  );

  // pad reset output from a flip-flop
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pad_reset_n_out <= 1'b0;
    end else begin
      pad_reset_n_out <= pad_cnt.done;
    end
  end

  // core held by any supply condition, pin reset or reset event
  assign por_lvl = ~pad_reset_n_out | ~core_por_s;
  assign any_cause = por_lvl | dip_s | wdog_cnt.done | pc_rollover_in |
                     sw_reset_in;
  assign core_hold = any_cause | ext_rst_act;

  // crystal edge count restarts whenever the core is held
  assign xtal_cnt.edge_lvl = xtal_s;
  assign xtal_cnt.clr = core_hold;

  rps_edge_cnt #(
    .W(rps_pkg::XTAL_CNT_W),
    .TARGET(rps_pkg::XTAL_EDGES)
  ) u_xtal_cnt (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .cnt(xtal_cnt)
  );

  // core reset output, released once crystal count completes
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      core_reset_n_out <= 1'b0;
    end else begin
      core_reset_n_out <= xtal_cnt.done & ~core_hold;
    end
  end

  // watchdog counts rc edges while the core runs
  assign wdog_cnt.edge_lvl = rc_s;
  assign wdog_cnt.clr = wdog_kick_in | ~core_reset_n_out;

  rps_edge_cnt #(
    .W(rps_pkg::WDOG_CNT_W),
    .TARGET(WDOG_RC_EDGES)
  ) u_wdog_cnt (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .cnt(wdog_cnt)
  );

  // cause priority: power-on, dip, watchdog, pc rollover, software
  always_comb begin
    next_cause = '0;
    if (por_lvl) begin
      next_cause[rps_pkg::CAUSE_POR_BIT] = 1'b1;
    end else if (dip_s) begin
      next_cause[rps_pkg::CAUSE_DIP_BIT] = 1'b1;
    end else if (wdog_cnt.done) begin
      next_cause[rps_pkg::CAUSE_WDOG_BIT] = 1'b1;
    end else if (pc_rollover_in) begin
      next_cause[rps_pkg::CAUSE_PC_BIT] = 1'b1;
    end else begin
      next_cause[rps_pkg::CAUSE_SW_BIT] = 1'b1;
    end
  end

  // reset source kept through reset, replaced by a new cause or set to power-on by pin reset
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || ext_rst_act) begin
      reset_cause_out <= rps_pkg::CAUSE_RESET;
    end else if (any_cause) begin
      reset_cause_out <= next_cause;
    end
  end

  // factory page enable set only by the debug port, cleared by it or by pin reset
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || ext_rst_act) begin
      fip_prog_en_out <= 1'b0;
    end else if (dbg_fip_unlock_in) begin
      fip_prog_en_out <= 1'b1;
    end else if (dbg_fip_lock_in) begin
      fip_prog_en_out <= 1'b0;
    end
  end

  assign fip_write_ok_out = fip_prog_en_out & fw_fip_write_in;

  // checks
  localparam int FILT_LAST = rps_pkg::EXT_FILT_CYC - 1;

  ext_filter_len_a: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(ext_rst_act) |->
      $past(filt_cnt) == rps_pkg::EXT_FILT_W'(FILT_LAST) && !$past(ext_s_n)
  ) else $error("pin reset taken without full filter time");

  glitch_reject_a: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    ext_s_n |=> !ext_rst_act ##1 !ext_rst_act
  ) else $error("pin reset active after pin went high");

  ext_core_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    ext_rst_act |=> !core_reset_n_out && !fip_prog_en_out
  ) else $error("core not held during pin reset");

  cause_onehot_a: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    $onehot(reset_cause_out)
  ) else $error("reset source not one-hot");

  cause_wdog_a: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    wdog_cnt.done && !por_lvl && !dip_s && !ext_rst_act |=>
      reset_cause_out[rps_pkg::CAUSE_WDOG_BIT]
  ) else $error("watchdog cause not recorded");

  cause_keep_a: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    !any_cause && !ext_rst_act |=> $stable(reset_cause_out)
  ) else $error("reset source changed without a cause");

  pad_release_a: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(pad_reset_n_out) |-> $past(pad_por_s, 2) && $past(rc_s, 2)
  ) else $error("pad released without supply or rc pulse");

  core_por_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    !core_por_s |=> !core_reset_n_out
  ) else $error("core released with core supply low");

  core_xtal_wait_a: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    $fell(core_hold) |=> !core_reset_n_out [*8]
  ) else $error("core released before crystal count");

  fip_debug_only_a: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    $rose(fip_prog_en_out) |-> $past(dbg_fip_unlock_in)
  ) else $error("page enable set without debug port");

  wdog_reset_a: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    wdog_cnt.done |=> !core_reset_n_out ##1 !wdog_cnt.done
  ) else $error("watchdog expiry did not reset core");
endmodule : rps_sequencer

// >>> include/rps_pkg.sv
// Functional notes
// - ext_reset_n held low over 200 ns resets the device
// - ext_reset_n is glitch filtered so short noise pulses are ignored
// - while ext_reset_n is asserted core logic and page enable are held in reset, pad domain is not
// - cause of each reset is recorded in a readable reset source field
// - five causes: power-on, watchdog, pc rollover, software, core dip
// - separate power-on detectors for core supply and pad supply
// - pad domain held until pad supply good and three rc pulses seen
// - core held in reset until the core supply detector releases
// - after supply good, count 1024 crystal edges before core release
// - two clock sources: crystal for core, rc oscillator for always-on
// - factory_info_page programming enabled only by serial_debug_port
// - watchdog on rc clock resets device after about two seconds
package rps_pkg;
  // system clock and filter timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int EXT_MIN_NS = 200;
  localparam int EXT_FILT_CYC = (EXT_MIN_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int EXT_FILT_W = 6;
  // edge counts for release sequencing
  localparam int RC_PULSES = 3;
  localparam int RC_CNT_W = 2;
  localparam int XTAL_EDGES = 1024;
  localparam int XTAL_CNT_W = 11;
  // watchdog timeout in rc edges
  localparam int WDOG_TIMEOUT_MS = 2000;
  localparam int RC_KHZ = 10;
  localparam int WDOG_RC_EDGES = WDOG_TIMEOUT_MS * RC_KHZ;
  localparam int WDOG_CNT_W = 15;
  // reset source one-hot bit positions
  localparam int CAUSE_W = 5;
  localparam int CAUSE_POR_BIT = 0;
  localparam int CAUSE_WDOG_BIT = 1;
  localparam int CAUSE_PC_BIT = 2;
  localparam int CAUSE_SW_BIT = 3;
  localparam int CAUSE_DIP_BIT = 4;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h01;
endpackage : rps_pkg

// >>> include/rps_cnt_if.sv
`timescale 1ns/100ps
// sampled clock level in, clear in, terminal count reached out
interface rps_cnt_if;
  logic edge_lvl;
  logic clr;
  logic done;
  modport owner (output edge_lvl, output clr, input done);
  modport counter (input edge_lvl, input clr, output done);
endinterface : rps_cnt_if

// >>> design/rps_sync.sv
`timescale 1ns/100ps
module rps_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_in, // system clock
  input wire logic rstn_in, // sync reset, active low
  input wire logic [W-1:0] async_in, // asynchronous levels
  output logic [W-1:0] sync_out // synchronised levels
);
  logic [W-1:0] meta;

  // two flip-flop synchroniser, first stage read only by the second
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : rps_sync

// >>> design/rps_edge_cnt.sv
`timescale 1ns/100ps
module rps_edge_cnt #(
  parameter int W = 2,
  parameter int TARGET = 3
) (
  input wire logic sys_clk_in, // system clock
  input wire logic rstn_in, // sync reset, active low
  rps_cnt_if.counter cnt // edge level, clear and done
);
  logic prev;
  logic [W-1:0] count;
  logic rise;

  assign rise = cnt.edge_lvl & ~prev;

  // previous sample for rising edge detection
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      prev <= 1'b0;
    end else begin
      prev <= cnt.edge_lvl;
    end
  end

  // saturating edge counter, clear wins
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || cnt.clr) begin
      count <= '0;
    end else if (rise && count != W'(TARGET)) begin
      count <= count + W'(1);
    end
  end

  assign cnt.done = (count == W'(TARGET)) & ~cnt.clr;
endmodule : rps_edge_cnt

// >>> verification/rps_supply_model.sv
`timescale 1ns/100ps
module rps_supply_model (
  input wire logic sys_clk_in, // system clock
  input wire logic pads_on_in, // pad supply ramped
  input wire logic core_on_in, // regulator ramped
  output logic rc_clk_out, // rc oscillator
  output logic xtal_clk_out, // crystal
  output logic pad_ok_out, // pad detector
  output logic core_ok_out // core detector
);
  int rc_cnt = 0;
  int xt_cnt = 0;
  logic rc_q = 1'b0;
  logic xt_q = 1'b0;
  // oscillators run all the time; rc period 40, crystal 6 cycles
  always @(posedge sys_clk_in) begin
    rc_cnt <= (rc_cnt == 19) ? 0 : rc_cnt + 1;
    xt_cnt <= (xt_cnt == 2) ? 0 : xt_cnt + 1;
    if (rc_cnt == 19) rc_q <= ~rc_q;
    if (xt_cnt == 2) xt_q <= ~xt_q;
  end
  // one driver for each oscillator pin
  assign rc_clk_out = rc_q;
  assign xtal_clk_out = xt_q;
  // detectors follow the supplies
  assign pad_ok_out = pads_on_in;
  assign core_ok_out = core_on_in;
endmodule : rps_supply_model

// >>> verification/reset_and_por_sequencer_test.sv
`timescale 1ns/100ps
module reset_and_por_sequencer_test;
  logic sys_clk_in = 1'b0, rstn_in = 1'b0, ext_n = 1'b1, dip = 1'b0;
  logic kick = 1'b1, pc = 1'b0, sw = 1'b0, unlk = 1'b0, lck = 1'b0;
  logic fw_wr = 1'b0, pads_on = 1'b0, core_on = 1'b0;
  logic rc, xt, pad_ok, core_ok, pad_n, core_n, prog_en, wr_ok;
  logic [4:0] cause;
  int num_errors = 0;
  int checks = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  rps_supply_model supply (.sys_clk_in(sys_clk_in), .pads_on_in(pads_on),
    .core_on_in(core_on), .rc_clk_out(rc), .xtal_clk_out(xt),
    .pad_ok_out(pad_ok), .core_ok_out(core_ok));
  rps_sequencer #(.WDOG_RC_EDGES(5)) DUT (.sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in), .ext_reset_n_in(ext_n), .pad_por_ok_in(pad_ok),
    .core_por_ok_in(core_ok), .core_dip_in(dip), .rc_clk_in(rc),
    .xtal_clk_in(xt), .wdog_kick_in(kick), .pc_rollover_in(pc),
    .sw_reset_in(sw), .dbg_fip_unlock_in(unlk), .dbg_fip_lock_in(lck),
    .fw_fip_write_in(fw_wr), .pad_reset_n_out(pad_n),
    .core_reset_n_out(core_n), .reset_cause_out(cause),
    .fip_prog_en_out(prog_en), .fip_write_ok_out(wr_ok));
  task complete_run;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task check(input logic [5:0] seen, input logic [5:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // step n edges, then let their updates land
  task cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : cyc
  // bounded wait for a reset output to release
  task wait_up(input int bound, input bit core);
    for (int i = 0; i < bound && (core ? core_n : pad_n) !== 1'b1; i++)
      cyc(1);
    if ((core ? core_n : pad_n) !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t release timeout", $time);
      complete_run();
    end
  endtask : wait_up
  // bounded wait for the core reset output to assert
  task wait_down(input int bound);
    for (int i = 0; i < bound && core_n !== 1'b0; i++)
      cyc(1);
    if (core_n !== 1'b0) begin
      num_errors++;
      $display("[FAIL] %0t core reset timeout", $time);
      complete_run();
    end
  endtask : wait_down
  task test_power_up;
    cyc(50);
    check({5'h00, pad_n}, 6'h00);
    check({1'b0, cause}, 6'h01);
    @(posedge sys_clk_in) pads_on <= 1'b1;
    cyc(20);
    check({5'h00, pad_n}, 6'h00);
    wait_up(200, 1'b0);
    cyc(200);
    check({5'h00, core_n}, 6'h00);
    @(posedge sys_clk_in) core_on <= 1'b1;
    cyc(5800);
    check({5'h00, core_n}, 6'h00);
    wait_up(800, 1'b1);
    $display("test power_up done");
  endtask : test_power_up
  task test_causes;
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk_in) {sw, pc} <= k ? 2'b10 : 2'b01;
      @(posedge sys_clk_in) {sw, pc} <= 2'b00;
      #1;
      check({5'h00, core_n}, 6'h00);
      check({1'b0, cause}, k ? 6'h08 : 6'h04);
      wait_up(7000, 1'b1);
      check({1'b0, cause}, k ? 6'h08 : 6'h04);
    end
    @(posedge sys_clk_in) dip <= 1'b1;
    cyc(10);
    check({1'b0, cause}, 6'h10);
    @(posedge sys_clk_in) dip <= 1'b0;
    wait_up(7000, 1'b1);
    @(posedge sys_clk_in) kick <= 1'b0;
    cyc(100);
    check({5'h00, core_n}, 6'h01);
    wait_down(300);
    check({1'b0, cause}, 6'h02);
    @(posedge sys_clk_in) kick <= 1'b1;
    wait_up(7000, 1'b1);
    $display("test causes done");
  endtask : test_causes
  task test_fip;
    @(posedge sys_clk_in) fw_wr <= 1'b1;
    cyc(3);
    check({4'h0, prog_en, wr_ok}, 6'h00);
    @(posedge sys_clk_in) unlk <= 1'b1;
    @(posedge sys_clk_in) unlk <= 1'b0;
    cyc(2);
    check({4'h0, prog_en, wr_ok}, 6'h03);
    @(posedge sys_clk_in) lck <= 1'b1;
    @(posedge sys_clk_in) lck <= 1'b0;
    cyc(2);
    check({4'h0, prog_en, wr_ok}, 6'h00);
    // lock and unlock together: unlock wins
    @(posedge sys_clk_in) {lck, unlk} <= 2'b11;
    @(posedge sys_clk_in) {lck, unlk} <= 2'b00;
    cyc(2);
    check({4'h0, prog_en, wr_ok}, 6'h03);
    @(posedge sys_clk_in) fw_wr <= 1'b0;
    cyc(2);
    check({4'h0, prog_en, wr_ok}, 6'h02);
    $display("test fip done");
  endtask : test_fip
  task test_pin;
    @(posedge sys_clk_in) ext_n <= 1'b0;
    cyc(30);
    @(posedge sys_clk_in) ext_n <= 1'b1;
    cyc(10);
    check({core_n, cause}, 6'h22);
    @(posedge sys_clk_in) ext_n <= 1'b0;
    cyc(70);
    check({core_n, cause}, 6'h01);
    check({4'h0, pad_n, prog_en}, 6'h02);
    @(posedge sys_clk_in) ext_n <= 1'b1;
    wait_up(7000, 1'b1);
    $display("test pin done");
  endtask : test_pin
  initial begin
    cyc(6);
    @(posedge sys_clk_in) rstn_in <= 1'b1;
    cyc(3);
    test_power_up();
    test_causes();
    test_fip();
    test_pin();
    complete_run();
  end
  initial begin
    #400000;
    num_errors++;
    $display("[FAIL] %0t run timeout", $time);
    complete_run();
  end
endmodule : reset_and_por_sequencer_test
